// *** src/sfsl_pkg.sv ***
// Purpose: Shared constants for the command block.
// Assumes: One 50 MHz core clock samples the SPI pins.
// Notes:   Every opcode, bit count, region address field and timing count lives here.
package sfsl_pkg;

  // Core clock period and the self-timed region erase time.
  localparam int CLK_PERIOD_NS   = 20;
  localparam int ERASE_TIME_NS   = 5000;
  localparam int ERASE_WAIT_CYC  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CNT_W     = 9;

  // Opcodes of the command group.
  localparam logic [7:0] OP_TABLE_READ  = 8'h5A;
  localparam logic [7:0] OP_REGION_ERA  = 8'h44;
  localparam logic [7:0] OP_REGION_PROG = 8'h42;
  localparam logic [7:0] OP_REGION_READ = 8'h48;
  localparam logic [7:0] OP_BLOCK_LOCK  = 8'h36;
  localparam logic [7:0] OP_BLOCK_ULOCK = 8'h39;

  // Rising-edge counts within a frame.
  localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
  localparam logic [5:0] CNT_ADDR_LAST   = 6'h1F;
  localparam logic [5:0] CNT_HDR_DONE    = 6'h20;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // Region address fields.
  localparam logic [7:0] REGION_HI_ZERO  = 8'h00;
  localparam logic [3:0] REGION_MID_ZERO = 4'h0;
  localparam logic [3:0] REGION_SEL_MIN  = 4'h1;
  localparam logic [3:0] REGION_SEL_MAX  = 4'h3;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam logic [7:0] BYTE_LAST       = 8'hFF;

  // Storage: page 0 holds the parameter table, pages 1 to 3 the regions.
  localparam int MEM_AW     = 10;
  localparam logic [1:0] TABLE_PAGE = 2'h0;

  // Volatile block locks, one per 64 KB block.
  localparam int NUM_BLOCKS = 16;
  localparam logic [15:0] LOCKS_RESET = 16'hFFFF;

  // Program data buffer.
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  // Command held for the current frame.
  typedef enum logic [6:0] {
    SFSL_CMD_NONE   = 7'b0000001,
    SFSL_CMD_TREAD  = 7'b0000010,
    SFSL_CMD_RREAD  = 7'b0000100,
    SFSL_CMD_PROG   = 7'b0001000,
    SFSL_CMD_ERASE  = 7'b0010000,
    SFSL_CMD_LOCK   = 7'b0100000,
    SFSL_CMD_ULOCK  = 7'b1000000
  } sfsl_cmd_e;

  // Self-timed engine states.
  typedef enum logic [4:0] {
    SFSL_ST_IDLE  = 5'b00001,
    SFSL_ST_ERASE = 5'b00010,
    SFSL_ST_EWAIT = 5'b00100,
    SFSL_ST_PROG  = 5'b01000,
    SFSL_ST_PROGW = 5'b10000
  } sfsl_state_e;

endpackage

// *** src/sfsl_mem.sv ***
// Purpose: Byte storage for the parameter table and the three security regions.
// Assumes: One access per cycle; read data appear one cycle after the request.
// Notes:   Contents are not cleared by reset, as in a non-volatile array.
`timescale 1ns/100ps
module sfsl_mem
  import sfsl_pkg::*;
(
  // Clock.
  input  wire logic              core_clk,
  // Access port.
  input  wire logic              mem_we,
  input  wire logic              mem_re,
  input  wire logic [MEM_AW-1:0] mem_addr,
  input  wire logic [7:0]        mem_wdata,
  output logic      [7:0]        mem_rdata
);

  logic [7:0] store [0:(1<<MEM_AW)-1];

  // Write and registered read share one address.
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      store[mem_addr] <= mem_wdata;
    end
    if (mem_re) begin
      mem_rdata <= store[mem_addr];
    end
  end

endmodule

// *** src/sfsl_fifo.sv ***
// Purpose: Small first-in first-out buffer for program data bytes.
// Assumes: Push and pop may share a cycle.
// Notes:   Output data come straight from the storage flip-flops.
`timescale 1ns/100ps
module sfsl_fifo
  import sfsl_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slot_reg [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come from the occupancy count.
  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = slot_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and count.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_reg <= PW'((rd_ptr_reg + 1'b1) % DEPTH);
      end
      count_reg <= (PW+1)'(count_reg + push - pop);
    end
  end

  // Storage is written only on an accepted push.
  always_ff @(posedge core_clk) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

// *** src/sfsl_top.sv ***
// Purpose: Command handling for table reads, security regions and block locks.
// Assumes: SPI mode 0 pins sampled by a faster core clock.
// Notes:   Busy is driven here; wel_clear pulses when a write command ends.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - A 256-byte read-only parameter table answers opcode 5Ah.
// - Table read: opcode, 24-bit address, eight dummies, data from falling edge 40.
// - Table read uses address bits 7 to 0 as the start byte.
// - Region erase 44h is accepted only while the write enable latch is set.
// - Region address: upper byte zero, bits 11-8 zero, bits 15-12 pick region 1-3.
// - Erase runs only when chip select rises right after the last address bit.
// - Erase is self-timed with busy high, busy falls when it finishes.
// - A region whose one-time lock bit is set ignores program and erase.
// - Region program 42h needs the latch; 1 to 256 bytes into erased cells.
// - Region read 48h: address, eight dummies, bytes out on falling edges, MSB first.
// - Region read address increments and wraps from FFh to 00h of the region.
// - A region read issued while busy is ignored.
// - Block locks apply only when the per-block select bit is set.
// - Block lock bits are volatile and reset to all ones.
// - Opcode 36h with address and chip select rise sets the block lock.
// - Opcode 39h with address and chip select rise clears the block lock.
module sfsl_top
  import sfsl_pkg::*;
(
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // SPI pins.
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_sclk,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       serial_out_oe,
  // Status bits from the status registers.
  input  wire logic                  write_enable_latch,
  input  wire logic                  per_block_protect_select,
  input  wire logic                  protect_complement,
  input  wire logic                  protect_granularity,
  input  wire logic                  protect_top_bottom,
  input  wire logic [2:0]            protect_extent_bits,
  input  wire logic [2:0]            region_otp_lock_bits,
  // Status and protection outputs.
  output logic                       busy,
  output logic                       wel_clear,
  output logic      [NUM_BLOCKS-1:0] block_lock_bits,
  output logic      [NUM_BLOCKS-1:0] block_lock_applied,
  output logic      [5:0]            legacy_protect_bits,
  // Factory load of the parameter table.
  input  wire logic                  table_load_valid,
  output logic                       table_load_ready,
  input  wire logic [7:0]            table_load_addr,
  input  wire logic [7:0]            table_load_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [2:0]   cs_sync_reg;
  logic [2:0]   sclk_sync_reg;
  logic [1:0]   si_sync_reg;
  logic         cs_high;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         cs_rise;
  logic         si_bit;
  logic [5:0]   cnt_reg;
  logic [2:0]   bit_reg;
  logic         extra_reg;
  logic [7:0]   shift_in_reg;
  logic [7:0]   opcode_reg;
  logic [23:0]  addr_reg;
  logic         decode_reg;
  logic         byte_done;
  logic [7:0]   byte_in;
  logic         region_ok;
  logic [1:0]   region_page;
  logic         region_locked;
  sfsl_cmd_e    cmd_reg;
  sfsl_state_e  state_reg;
  logic [1:0]   page_reg;
  logic [7:0]   ptr_reg;
  logic         fetch_reg;
  logic [7:0]   out_shift_reg;
  logic         out_live_reg;
  logic [ERASE_CNT_W-1:0] wait_reg;
  logic         exec_at_rise;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [7:0]   fifo_out_data;
  logic         mem_we;
  logic         mem_re;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0]   mem_wdata;
  logic [7:0]   mem_rdata;
  logic         reading;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are found between the second and third stages.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h0;
      si_sync_reg   <= 2'h0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
      si_sync_reg   <= {si_sync_reg[0], serial_in};
    end
  end

  assign cs_high   = cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sclk_rise = ~cs_high & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~cs_high & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign si_bit    = si_sync_reg[1];
  assign byte_in   = {shift_in_reg[6:0], si_bit};
  // A data byte ends on every eighth rising edge after the header.
  assign byte_done = sclk_rise & (cnt_reg == CNT_HDR_DONE) & (bit_reg == BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame counters; the count stops at 32 and a bit counter runs beyond it.
  always_ff @(posedge core_clk) begin
    if (rst || cs_high) begin
      cnt_reg   <= 6'h00;
      bit_reg   <= 3'h0;
      extra_reg <= 1'b0;
    end else if (sclk_rise) begin
      if (cnt_reg != CNT_HDR_DONE) begin
        cnt_reg <= cnt_reg + 6'h01;
      end else begin
        bit_reg   <= bit_reg + 3'h1;
        extra_reg <= 1'b1;
      end
    end
  end

  // Opcode and address are shifted in on rising edges, MSB first.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_in_reg <= 8'h00;
      opcode_reg   <= 8'h00;
      addr_reg     <= 24'h000000;
      decode_reg   <= 1'b0;
    end else begin
      decode_reg <= sclk_rise & (cnt_reg == CNT_ADDR_LAST);
      if (sclk_rise) begin
        shift_in_reg <= byte_in;
        if (cnt_reg == CNT_OPCODE_LAST) begin
          opcode_reg <= byte_in;
        end else if (cnt_reg > CNT_OPCODE_LAST && cnt_reg < CNT_HDR_DONE) begin
          addr_reg <= {addr_reg[22:0], si_bit};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Region address check and one-time lock lookup.
  assign region_ok = (addr_reg[23:16] == REGION_HI_ZERO) &&
                     (addr_reg[11:8] == REGION_MID_ZERO) &&
                     (addr_reg[15:12] >= REGION_SEL_MIN) &&
                     (addr_reg[15:12] <= REGION_SEL_MAX);
  assign region_page   = addr_reg[13:12];
  assign region_locked = region_otp_lock_bits[region_page - 2'h1];
  assign busy          = (state_reg != SFSL_ST_IDLE);

  // Command decode once the address is complete; cleared when the frame ends.
  always_ff @(posedge core_clk) begin
    if (rst || cs_high) begin
      cmd_reg <= SFSL_CMD_NONE;
    end else if (decode_reg) begin
      cmd_reg <= SFSL_CMD_NONE;
      if (opcode_reg == OP_TABLE_READ && !busy) begin
        cmd_reg <= SFSL_CMD_TREAD;
      end else if (opcode_reg == OP_REGION_READ && !busy && region_ok) begin
        cmd_reg <= SFSL_CMD_RREAD;
      end else if (write_enable_latch && !busy) begin
        if (opcode_reg == OP_REGION_PROG && region_ok && !region_locked) begin
          cmd_reg <= SFSL_CMD_PROG;
        end else if (opcode_reg == OP_REGION_ERA && region_ok && !region_locked) begin
          cmd_reg <= SFSL_CMD_ERASE;
        end else if (opcode_reg == OP_BLOCK_LOCK) begin
          cmd_reg <= SFSL_CMD_LOCK;
        end else if (opcode_reg == OP_BLOCK_ULOCK) begin
          cmd_reg <= SFSL_CMD_ULOCK;
        end
      end
    end
  end

  // Commands that act on chip select rise need exactly 32 bits in the frame.
  assign exec_at_rise = cs_rise && (cnt_reg == CNT_HDR_DONE) && !extra_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Volatile block locks, all set by reset; they protect the array only while the per-block select is set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      block_lock_bits <= LOCKS_RESET;
    end else if (exec_at_rise && cmd_reg == SFSL_CMD_LOCK) begin
      block_lock_bits[addr_reg[19:16]] <= 1'b1;
    end else if (exec_at_rise && cmd_reg == SFSL_CMD_ULOCK) begin
      block_lock_bits[addr_reg[19:16]] <= 1'b0;
    end
  end

  // Only one protection scheme is offered to the array at a time.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      block_lock_applied  <= '0;
      legacy_protect_bits <= 6'h00;
    end else if (per_block_protect_select) begin
      block_lock_applied  <= block_lock_bits;
      legacy_protect_bits <= 6'h00;
    end else begin
      block_lock_applied  <= '0;
      legacy_protect_bits <= {protect_complement, protect_granularity,
                              protect_top_bottom, protect_extent_bits};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Self-timed engine: region erase walk, erase wait, and program drain.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= SFSL_ST_IDLE;
      wait_reg  <= '0;
      wel_clear <= 1'b0;
    end else begin
      wel_clear <= 1'b0;
      case (state_reg)
        SFSL_ST_IDLE: begin
          if (exec_at_rise && cmd_reg == SFSL_CMD_ERASE) begin
            state_reg <= SFSL_ST_ERASE;
          end else if (decode_reg && cmd_reg == SFSL_CMD_NONE && write_enable_latch &&
                       opcode_reg == OP_REGION_PROG && region_ok && !region_locked) begin
            state_reg <= SFSL_ST_PROG;
          end else if (exec_at_rise && (cmd_reg == SFSL_CMD_LOCK ||
                                        cmd_reg == SFSL_CMD_ULOCK)) begin
            wel_clear <= 1'b1;
          end
        end
        SFSL_ST_ERASE: begin
          if (ptr_reg == BYTE_LAST) begin
            state_reg <= SFSL_ST_EWAIT;
            wait_reg  <= '0;
          end
        end
        SFSL_ST_EWAIT: begin
          wait_reg <= wait_reg + 1'b1;
          if (wait_reg == ERASE_CNT_W'(ERASE_WAIT_CYC - 1)) begin
            state_reg <= SFSL_ST_IDLE;
            wel_clear <= 1'b1;
          end
        end
        SFSL_ST_PROG: begin
          // The program ends once the frame has closed and the buffer is empty.
          if (fifo_out_valid) begin
            state_reg <= SFSL_ST_PROGW;
          end else if (cs_high) begin
            state_reg <= SFSL_ST_IDLE;
            wel_clear <= 1'b1;
          end
        end
        SFSL_ST_PROGW: begin
          state_reg <= SFSL_ST_PROG;
        end
        default: begin
          state_reg <= SFSL_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Page and byte pointer shared by read, program and erase.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      page_reg  <= TABLE_PAGE;
      ptr_reg   <= 8'h00;
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= 1'b0;
      if (state_reg == SFSL_ST_IDLE && exec_at_rise && cmd_reg == SFSL_CMD_ERASE) begin
        page_reg <= region_page;
        ptr_reg  <= 8'h00;
      end else if (state_reg == SFSL_ST_ERASE) begin
        ptr_reg <= ptr_reg + 8'h01;
      end else if (state_reg == SFSL_ST_PROGW) begin
        ptr_reg <= ptr_reg + 8'h01;
      end else if (decode_reg && !busy) begin
        // Table reads take only the low address byte as the start offset.
        page_reg  <= (opcode_reg == OP_TABLE_READ) ? TABLE_PAGE : region_page;
        ptr_reg   <= addr_reg[7:0];
        fetch_reg <= 1'b1;
      end else if (byte_done && reading) begin
        ptr_reg   <= ptr_reg + 8'h01;
        fetch_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory port arbitration; the engine wins, table loading goes ahead only in idle with no read.
  assign reading          = (cmd_reg == SFSL_CMD_TREAD) || (cmd_reg == SFSL_CMD_RREAD);
  assign table_load_ready = (state_reg == SFSL_ST_IDLE) && !fetch_reg && !reading;
  assign fifo_out_ready   = (state_reg == SFSL_ST_PROGW);

  always_comb begin
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_addr  = {page_reg, ptr_reg};
    mem_wdata = ERASED_BYTE;
    if (state_reg == SFSL_ST_ERASE) begin
      mem_we = 1'b1;
    end else if (state_reg == SFSL_ST_PROG) begin
      mem_re = fifo_out_valid;
    end else if (state_reg == SFSL_ST_PROGW) begin
      // Programming only clears bits, so the old byte is merged in.
      mem_we    = 1'b1;
      mem_wdata = mem_rdata & fifo_out_data;
    end else if (fetch_reg) begin
      mem_re = 1'b1;
    end else if (table_load_valid && table_load_ready) begin
      mem_we    = 1'b1;
      mem_addr  = {TABLE_PAGE, table_load_addr};
      mem_wdata = table_load_data;
    end
  end

  sfsl_mem u_mem (
    .core_clk  (core_clk),
    .mem_we    (mem_we),
    .mem_re    (mem_re),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );

  // Program bytes are buffered; the drain empties it long before it fills.
  sfsl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (byte_done && cmd_reg == SFSL_CMD_PROG),
    .in_ready  (fifo_in_ready),
    .in_data   (byte_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output shifter: loaded on rising edge 40 and every eighth after, shifted on falls.
  always_ff @(posedge core_clk) begin
    if (rst || cs_high) begin
      out_shift_reg <= 8'h00;
      out_live_reg  <= 1'b0;
      serial_out    <= 1'b0;
    end else begin
      if (byte_done && reading) begin
        out_shift_reg <= mem_rdata;
        out_live_reg  <= 1'b1;
      end else if (sclk_fall && out_live_reg) begin
        serial_out    <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end

  // The pin is driven only while a read is under way in this frame.
  assign serial_out_oe = reading & ~cs_high;

endmodule

// *** bench/sfsl_checker_asserts.sv ***
// Purpose: Port assertions for the command block.
// Assumes: One clock, synchronous reset.
// Notes:   Latencies allow for the synchronisers.
`timescale 1ns/100ps
module sfsl_checker
  import sfsl_pkg::*;
(
  // Clock, reset and pins.
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        spi_cs_n,
  input wire logic        spi_sclk,
  input wire logic        serial_out,
  input wire logic        serial_out_oe,
  // Status inputs.
  input wire logic        write_enable_latch,
  input wire logic        per_block_protect_select,
  input wire logic        protect_complement,
  input wire logic        protect_granularity,
  input wire logic        protect_top_bottom,
  input wire logic [2:0]  protect_extent_bits,
  // Outputs.
  input wire logic        busy,
  input wire logic        wel_clear,
  input wire logic [15:0] block_lock_bits,
  input wire logic [15:0] block_lock_applied,
  input wire logic [5:0]  legacy_protect_bits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Chip select high past the synchronisers.
  sequence cs_idle_s;
    spi_cs_n [*4];
  endsequence
  sequence lock_edit_s;
    $changed(block_lock_bits);
  endsequence
  reset_locks_a: assert property (disable iff (1'b0) rst |=> block_lock_bits == LOCKS_RESET)
    else $error("locks not set by reset");
  applied_sel_a: assert property (!$past(rst) |-> block_lock_applied ==
    ($past(per_block_protect_select) ? $past(block_lock_bits) : 16'h0))
    else $error("applied locks wrong");
  legacy_sel_a: assert property (!$past(rst) |-> legacy_protect_bits ==
    ($past(per_block_protect_select) ? 6'h00 : $past({protect_complement,
    protect_granularity, protect_top_bottom, protect_extent_bits})))
    else $error("legacy bits wrong");
  lock_needs_wel_a: assert property (lock_edit_s |-> $past(write_enable_latch))
    else $error("lock change without latch");
  lock_done_a: assert property (lock_edit_s |-> wel_clear)
    else $error("lock change without latch clear");
  wel_pulse_a: assert property (wel_clear |=> !wel_clear)
    else $error("latch clear too long");
  busy_wel_a: assert property ($rose(busy) |-> write_enable_latch)
    else $error("busy without latch");
  busy_end_a: assert property ($fell(busy) |-> wel_clear)
    else $error("busy end without latch clear");
  read_busy_a: assert property (busy |-> !serial_out_oe)
    else $error("output enabled while busy");
  out_edge_a: assert property ($changed(serial_out) && serial_out_oe |-> !spi_sclk)
    else $error("data out moved with clock high");
  oe_release_a: assert property (cs_idle_s |-> !serial_out_oe)
    else $error("output enable after frame");
endmodule

// *** bench/sfsl_host.sv ***
// Purpose: SPI host model framing commands.
// Assumes: Mode 0, link clock of eight core cycles, low between frames.
// Notes:   Data in is inverted on release, never left stale.
`timescale 1ns/100ps
module sfsl_host (
  // Core clock.
  input  wire logic core_clk,
  // SPI pins.
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic [15:0] rx;
  logic        oe_seen;
  ////////////////////////////////////////
  // Idle pins at time zero.
  initial begin
    {spi_cs_n, spi_sclk, serial_in, oe_seen} = 4'b1000;
    rx = 16'h0000;
  end
  // Half a link period, 80 ns.
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  // Header MSB first, then data bytes; the answer is sampled at each rise.
  task automatic frame(input logic [31:0] hdr, input int nclk, input logic [7:0] dat = 8'h00);
    oe_seen  = 1'b0;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      serial_in = (i < 32) ? hdr[31-i] : dat[7-(i%8)];
      half();
      spi_sclk = 1'b1;
      rx       = {rx[14:0], serial_out};
      oe_seen  = oe_seen | serial_out_oe;
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n  = 1'b1;
    serial_in = ~serial_in;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// *** bench/sfsl_top_test.sv ***
// Purpose: Self-checking bench for the command block.
// Assumes: Inputs change on falling edges.
// Notes:   Table byte n holds the inverse of n.
`timescale 1ns/100ps
module sfsl_top_test;
  import sfsl_pkg::*;
  logic        core_clk, rst, spi_cs_n, spi_sclk, serial_in, serial_out, serial_out_oe;
  logic        write_enable_latch, per_block_protect_select, protect_complement;
  logic        protect_granularity, protect_top_bottom, busy, wel_clear;
  logic        table_load_valid, table_load_ready;
  logic [2:0]  protect_extent_bits, region_otp_lock_bits;
  logic [15:0] block_lock_bits, block_lock_applied;
  logic [5:0]  legacy_protect_bits;
  logic [7:0]  table_load_addr, table_load_data;
  int          num_errors = 0, check_count = 0, wc_cnt = 0, n;
  logic [31:0] row_hdr [3] = '{32'h5A000010, 32'h5A00007F, 32'h5A0000FF};
  logic [15:0] row_exp [3] = '{16'hEFEE, 16'h807F, 16'h00FF};
  sfsl_top dut (.core_clk, .rst, .spi_cs_n, .spi_sclk, .serial_in, .serial_out, .serial_out_oe,
    .write_enable_latch, .per_block_protect_select, .protect_complement, .protect_granularity,
    .protect_top_bottom, .protect_extent_bits, .region_otp_lock_bits, .busy, .wel_clear,
    .block_lock_bits, .block_lock_applied, .legacy_protect_bits, .table_load_valid,
    .table_load_ready, .table_load_addr, .table_load_data);
  sfsl_host host (.core_clk, .spi_cs_n, .spi_sclk, .serial_in, .serial_out, .serial_out_oe);
  ////////////////////////////////////////
  // Clock, latch clear counter and watchdog.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wel_clear === 1'b1) wc_cnt <= wc_cnt + 1;
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for the self-timed engine.
  task automatic wait_idle();
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge core_clk);
    check("busy", 16'h0, {15'h0, busy});
  endtask
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    {write_enable_latch, per_block_protect_select, protect_complement} = 3'h0;
    {protect_granularity, protect_top_bottom, protect_extent_bits} = 5'h00;
    {region_otp_lock_bits, table_load_valid, table_load_addr, table_load_data} = 20'h00000;
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    check("locks", 16'hFFFF, block_lock_bits);
    // Load the table; each byte waits for ready at a rising edge.
    for (n = 0; n < 256; n++) begin
      @(negedge core_clk);
      {table_load_valid, table_load_addr, table_load_data} = {1'b1, n[7:0], ~n[7:0]};
      do @(posedge core_clk); while (table_load_ready !== 1'b1);
    end
    @(negedge core_clk);
    table_load_valid = 1'b0;
    for (n = 0; n < 3; n++) begin
      host.frame(row_hdr[n], 56);
      check("table", row_exp[n], host.rx);
    end
    per_block_protect_select = 1'b1;
    host.frame(32'h39050000, 32);
    check("locks", 16'hFFFF, block_lock_bits);
    write_enable_latch = 1'b1;
    host.frame(32'h39050000, 32);
    check("locks", 16'hFFDF, block_lock_bits);
    host.frame(32'h36050000, 33);
    check("locks", 16'hFFDF, block_lock_bits);
    check("applied", 16'hFFDF, block_lock_applied);
    host.frame(32'h36050000, 32);
    check("locks", 16'hFFFF, block_lock_bits);
    check("latch clears", 16'h2, wc_cnt[15:0]);
    per_block_protect_select = 1'b0;
    {protect_complement, protect_top_bottom, protect_extent_bits} = 5'h1D;
    repeat (2) @(negedge core_clk);
    check("applied", 16'h0, block_lock_applied);
    check("legacy", 16'h2D, {10'h0, legacy_protect_bits});
    // Erase refusals, then an erase with a read meanwhile.
    write_enable_latch = 1'b0;
    host.frame(32'h44002000, 32);
    check("busy", 16'h0, {15'h0, busy});
    write_enable_latch = 1'b1;
    host.frame(32'h44004000, 32);
    check("busy", 16'h0, {15'h0, busy});
    host.frame(32'h44002000, 32);
    check("busy", 16'h1, {15'h0, busy});
    host.frame(32'h48002000, 56);
    check("oe while busy", 16'h0, {15'h0, host.oe_seen});
    wait_idle();
    host.frame(32'h420020FF, 48, 8'h3C);
    wait_idle();
    host.frame(32'h480020FF, 56);
    check("region", 16'h3C3C, host.rx);
    region_otp_lock_bits = 3'h2;
    host.frame(32'h44002000, 32);
    check("busy", 16'h0, {15'h0, busy});
    host.frame(32'h42002000, 40);
    wait_idle();
    host.frame(32'h480020FF, 56);
    check("region", 16'h3C3C, host.rx);
    print_verdict();
  end
endmodule
bind sfsl_top sfsl_checker u_chk (.core_clk, .rst, .spi_cs_n, .spi_sclk, .serial_out,
  .serial_out_oe, .write_enable_latch, .per_block_protect_select, .protect_complement,
  .protect_granularity, .protect_top_bottom, .protect_extent_bits, .busy, .wel_clear,
  .block_lock_bits, .block_lock_applied, .legacy_protect_bits);
